// [rtl/sdr_pkg.sv]
// Shared constants and types for the sigma-delta result and status block.
package sdr_pkg;

   // Data widths of the result path and the CPU side.
   localparam int RES_W = 16;
   localparam int BYTE_W = 8;
   localparam int CHAN_W = 2;
   localparam int NSEL_W = 3;
   localparam int ADDR_W = 16;
   localparam int RESB_W = 5;

   // Byte addresses of the readable registers.
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'hFF75;
   localparam logic [ADDR_W-1:0] ADDR_RES_LO = 16'hFF7E;
   localparam logic [ADDR_W-1:0] ADDR_RES_HI = 16'hFF7F;

   // Reset values.
   localparam logic [RES_W-1:0] RES_RST = 16'h0000;
   localparam logic [BYTE_W-1:0] HI_RST = 8'h00;
   localparam logic [BYTE_W-1:0] STAT_RST = 8'h00;
   localparam logic [RES_W-1:0] RDATA_RST = 16'h0000;

   // Field position of the converted-channel code in the status register.
   localparam int STAT_CHAN_LSB = 0;
   localparam int HI_LSB = 8;

   // Resolution in bits for sample count codes 7 down to 0.
   localparam logic [8*RESB_W-1:0] RES_BITS_TABLE = {
      5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h08
   };

   // Channel codes recorded after a conversion.
   typedef enum logic [CHAN_W-1:0] {
      SDR_CH0 = 2'h0,
      SDR_CH1 = 2'h1,
      SDR_CH2 = 2'h2
   } sdr_chan_t;

   // Result freshness tracking, Gray along empty, fresh, taken.
   typedef enum logic [1:0] {
      SDR_EMPTY = 2'h0,
      SDR_FRESH = 2'h1,
      SDR_TAKEN = 2'h3,
      SDR_LOST = 2'h2
   } sdr_fsm_t;

endpackage

// [rtl/sdr_align.sv]
// Left-aligns a modulator result and zeroes the bits below the resolution.
`timescale 1ns/10ps
module sdr_align
   import sdr_pkg::*;
(
   // Raw value, right-aligned N-bit result.
   input wire logic [RES_W-1:0] raw_i,
   // Sample count code.
   input wire logic [NSEL_W-1:0] sel_i,
   // Left-aligned result.
   output logic [RES_W-1:0] aligned_o
);

   logic [RESB_W-1:0] res_bits;
   logic [RESB_W-1:0] shift;
   logic [RES_W-1:0] shifted;

   // Look up the resolution and the left shift that puts the MSB at bit 15.
   always_comb begin
      res_bits = RES_BITS_TABLE[sel_i*RESB_W +: RESB_W];
      shift = RESB_W'(RES_W) - res_bits;
      shifted = raw_i << shift;
   end

   // Per bit: keep it only inside the top res_bits positions.
   for (genvar i = 0; i < RES_W; i++) begin : g_mask
      assign aligned_o[i] = (RESB_W'(i) >= shift) ? shifted[i] : 1'b0;
   end

endmodule // sdr_align

// [rtl/sdr_rd_mux.sv]
// Address decode and read data selection for the result and status registers.
`timescale 1ns/10ps
module sdr_rd_mux
   import sdr_pkg::*;
(
   // Access request.
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic word_i,
   // Register contents.
   input wire logic [RES_W-1:0] result_i,
   input wire logic [BYTE_W-1:0] high_i,
   input wire logic [BYTE_W-1:0] status_i,
   // Selected data and decode results.
   output logic [RES_W-1:0] data_o,
   output logic hit_o,
   output logic takes_result_o
);

   // Word reads only answer at the result word; byte reads at three addresses.
   always_comb begin
      data_o = RDATA_RST;
      hit_o = 1'b0;
      takes_result_o = 1'b0;
      if (word_i) begin
         if (addr_i == ADDR_RES_LO) begin
            data_o = result_i;
            hit_o = 1'b1;
            takes_result_o = 1'b1;
         end
      end else begin
         unique case (addr_i)
            ADDR_RES_LO: begin
               data_o = {HI_RST, result_i[BYTE_W-1:0]};
               hit_o = 1'b1;
            end
            ADDR_RES_HI: begin
               data_o = {HI_RST, high_i};
               hit_o = 1'b1;
               takes_result_o = 1'b1;
            end
            ADDR_STATUS: begin
               data_o = {HI_RST, status_i};
               hit_o = 1'b1;
            end
            default: begin
               data_o = RDATA_RST;
            end
         endcase
      end
   end

endmodule // sdr_rd_mux

// [rtl/sdr_result.sv]
// Result, upper-byte and converted-channel registers of the sigma-delta converter.
// Operation
// - Each conversion end loads the new modulator result into the 16-bit result register.
// - The upper result byte answers at FF7FH and the lower byte at FF7EH.
// - A single 16-bit read returns the whole result register.
// - Reset clears the 16-bit result register to zero.
// - Below 16 bits the result is left-aligned and the unused low bits read zero.
// - Each completion raises the interrupt; a read colliding with the update is undefined.
// - A separate 8-bit register holds the upper eight bits of the result.
// - The upper-byte register is read-only by byte access and resets to zero.
// - A status register records the channel of the last completed conversion.
// - Status bits 1:0 encode channel 0, 1 or 2 as 00, 01 or 10.
// - The status register reads by byte, bits 7 to 2 read zero, and it resets to zero.
// - A three-bit code selects 256 to 65536 samples, that is 8 to 16 bits of resolution.
// - The input mode bit selects single-ended (0) or differential (1) channel meaning.
`timescale 1ns/10ps
module sdr_result
   import sdr_pkg::*;
(
   // Clock and reset.
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // Modulator side, same clock domain.
   input wire logic CONV_DONE_I,
   input wire logic [RES_W-1:0] CONV_RAW_I,
   input wire logic [CHAN_W-1:0] CONV_CHAN_I,
   // Control settings held by the control registers.
   input wire logic [NSEL_W-1:0] SAMPLE_SEL_I,
   input wire logic INPUT_MODE_I,
   // CPU read port.
   input wire logic [ADDR_W-1:0] CPU_ADDR_I,
   input wire logic CPU_RD_I,
   input wire logic CPU_WORD_I,
   output logic [RES_W-1:0] CPU_RDATA_O,
   output logic CPU_RACK_O,
   output logic CPU_RHIT_O,
   // Completion and freshness.
   output logic CONV_INT_O,
   output logic RESULT_FRESH_O,
   output logic RESULT_LOST_O,
   output logic INPUT_MODE_O
);

   // Result and status registers.
   logic [RES_W-1:0] result_q;
   logic [RES_W-1:0] result_d;
   logic [BYTE_W-1:0] high_q;
   logic [BYTE_W-1:0] high_d;
   logic [BYTE_W-1:0] status_q;
   logic [BYTE_W-1:0] status_d;
   logic mode_q;
   logic mode_d;
   logic int_q;
   logic int_d;

   // Read port registers.
   logic [RES_W-1:0] rdata_q;
   logic [RES_W-1:0] rdata_d;
   logic rack_q;
   logic rack_d;
   logic rhit_q;
   logic rhit_d;

   // Freshness tracking, with the two flags registered from the next state.
   sdr_fsm_t state_q;
   sdr_fsm_t state_d;
   logic fresh_q;
   logic lost_q;

   // Combinational helpers.
   logic [RES_W-1:0] aligned;
   logic [RES_W-1:0] mux_data;
   logic mux_hit;
   logic mux_takes;
   logic result_read;
   sdr_chan_t chan_code;

   // Left-aligns the raw value to the selected resolution.
   sdr_align u_align (
      .raw_i(CONV_RAW_I),
      .sel_i(SAMPLE_SEL_I),
      .aligned_o(aligned)
   );

   // Decodes the CPU address and picks the register contents.
   sdr_rd_mux u_rd_mux (
      .addr_i(CPU_ADDR_I),
      .word_i(CPU_WORD_I),
      .result_i(result_q),
      .high_i(high_q),
      .status_i(status_q),
      .data_o(mux_data),
      .hit_o(mux_hit),
      .takes_result_o(mux_takes)
   );

   // The channel code is kept as given; the prohibited code 11 is never
   // produced by a legal setting, so no correction is attempted here.
   always_comb begin
      chan_code = sdr_chan_t'(CONV_CHAN_I);
   end

   // A read counts as consuming the result only if it is a word read at FF7EH or a byte read of the upper byte.
   always_comb begin
      result_read = CPU_RD_I && mux_takes;
   end

   // Next values of the result, upper byte, status and interrupt.
   always_comb begin
      result_d = result_q;
      high_d = high_q;
      status_d = status_q;
      mode_d = mode_q;
      int_d = 1'b0;
      if (CONV_DONE_I) begin
         result_d = aligned;
         high_d = aligned[HI_LSB +: BYTE_W];
         status_d = STAT_RST;
         status_d[STAT_CHAN_LSB +: CHAN_W] = chan_code;
         mode_d = INPUT_MODE_I;
         int_d = 1'b1;
      end
   end

   // Registers only; all four data registers move on the same edge.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         result_q <= RES_RST;
         high_q <= HI_RST;
         status_q <= STAT_RST;
         mode_q <= 1'b0;
         int_q <= 1'b0;
      end else begin
         result_q <= result_d;
         high_q <= high_d;
         status_q <= status_d;
         mode_q <= mode_d;
         int_q <= int_d;
      end
   end

   // Read answers one cycle after the request. A read in the same cycle as a
   // completion returns the old contents: deterministic, which the undefined
   // case allows, and it keeps word reads from mixing two results.
   always_comb begin
      rdata_d = rdata_q;
      rack_d = 1'b0;
      rhit_d = 1'b0;
      if (CPU_RD_I) begin
         rdata_d = mux_data;
         rack_d = 1'b1;
         rhit_d = mux_hit;
      end
   end

   // Read port registers.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         rdata_q <= RDATA_RST;
         rack_q <= 1'b0;
         rhit_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rack_q <= rack_d;
         rhit_q <= rhit_d;
      end
   end

   // Freshness follows the read window that software is expected to keep.
   // A completion while a result is still unread marks it lost; a completion
   // in the same cycle as a read wins over the read.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         SDR_EMPTY: begin
            if (CONV_DONE_I) begin
               state_d = SDR_FRESH;
            end
         end
         SDR_FRESH: begin
            if (CONV_DONE_I && !result_read) begin
               state_d = SDR_LOST;
            end else if (!CONV_DONE_I && result_read) begin
               state_d = SDR_TAKEN;
            end
         end
         SDR_TAKEN: begin
            if (CONV_DONE_I) begin
               state_d = SDR_FRESH;
            end
         end
         SDR_LOST: begin
            if (result_read && !CONV_DONE_I) begin
               state_d = SDR_TAKEN;
            end
         end
      endcase
   end

   // Freshness state register.
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         state_q <= SDR_EMPTY;
         fresh_q <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fresh_q <= (state_d == SDR_FRESH);
         lost_q <= (state_d == SDR_LOST);
      end
   end

   // Outputs straight from flip-flops, the flags included, so no decode glitch escapes.
   assign CPU_RDATA_O = rdata_q;
   assign CPU_RACK_O = rack_q;
   assign CPU_RHIT_O = rhit_q;
   assign CONV_INT_O = int_q;
   assign RESULT_FRESH_O = fresh_q;
   assign RESULT_LOST_O = lost_q;
   assign INPUT_MODE_O = mode_q;

endmodule // sdr_result

// [verif/sdr_result_assertions.sv]
// Concurrent checks on the ports of the result and status block.
`timescale 1ns/10ps
module sdr_result_assertions
   import sdr_pkg::*;
(
   // Clock, reset and watched ports.
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic CONV_DONE_I,
   input wire logic [ADDR_W-1:0] CPU_ADDR_I,
   input wire logic CPU_RD_I,
   input wire logic CPU_WORD_I,
   input wire logic [RES_W-1:0] CPU_RDATA_O,
   input wire logic CPU_RACK_O,
   input wire logic CPU_RHIT_O,
   input wire logic CONV_INT_O
);
   // One clock domain, so all checks share the clock and sleep during reset.
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   property p_int; CONV_DONE_I |=> CONV_INT_O; endproperty
   property p_int_once; !CONV_DONE_I |=> !CONV_INT_O; endproperty
   property p_rack; CPU_RD_I |=> CPU_RACK_O ##0 !$stable(CPU_RACK_O) || $past(CPU_RD_I, 2); endproperty
   property p_rd_hold; !CPU_RD_I |=> $stable(CPU_RDATA_O); endproperty
   property p_stat;
      CPU_RD_I && !CPU_WORD_I && CPU_ADDR_I == ADDR_STATUS |=> CPU_RHIT_O && CPU_RDATA_O[15:2] == 14'h0;
   endproperty
   property p_high;
      CPU_RD_I && !CPU_WORD_I && CPU_ADDR_I == ADDR_RES_HI |=> CPU_RHIT_O && CPU_RDATA_O[15:8] == 8'h00;
   endproperty
   property p_word_map; CPU_RD_I && CPU_WORD_I |=> CPU_RHIT_O == ($past(CPU_ADDR_I) == ADDR_RES_LO); endproperty
   property p_unmap;
      CPU_RD_I && !CPU_WORD_I && CPU_ADDR_I[15:8] != 8'hFF |=> !CPU_RHIT_O && CPU_RDATA_O == 16'h0000;
   endproperty
   a_int: assert property (p_int) else $error("completion pulse missing");
   a_int_once: assert property (p_int_once) else $error("completion pulse without done");
   a_rack: assert property (p_rack) else $error("read answer missing");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
   a_stat: assert property (p_stat) else $error("status upper bits not zero");
   a_high: assert property (p_high) else $error("upper byte read badly placed");
   a_word_map: assert property (p_word_map) else $error("word decode wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped byte answered");
   // Main traffic seen at least once.
   c_int: cover property (CONV_DONE_I ##1 CONV_INT_O);
   c_word: cover property (CPU_RD_I && CPU_WORD_I ##1 CPU_RHIT_O);
   c_miss: cover property (CPU_RD_I ##1 !CPU_RHIT_O);
endmodule // sdr_result_assertions

// [verif/sdr_mod_model.sv]
// Behavioural modulator that hands finished conversions to the result block.
`timescale 1ns/10ps
module sdr_mod_model
   import sdr_pkg::*;
(
   // Request from the bench.
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [RES_W-1:0] raw_i,
   input wire logic [CHAN_W-1:0] chan_i,
   // Conversion output.
   output logic done_o,
   output logic [RES_W-1:0] raw_o,
   output logic [CHAN_W-1:0] chan_o
);
   initial begin
      done_o = 1'b0;
      raw_o = 16'h5A5A;
      chan_o = 2'h3;
   end
   // Data is valid only with done; otherwise it toggles, so a late sample never matches.
   // The model hands over finished results only, so the sampling clock and reference
   // limits are kept by construction: no prohibited setting reaches the block.
   always @(posedge clk_i) begin
      done_o <= go_i;
      raw_o <= go_i ? raw_i : ~raw_o;
      chan_o <= go_i ? chan_i : ~chan_o;
   end
endmodule // sdr_mod_model

// [verif/sdr_result_tb_top.sv]
// Testbench top for the sigma-delta result and status block.
`timescale 1ns/10ps
module sdr_result_tb_top;
   import sdr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic go = 1'b0;
   logic [RES_W-1:0] raw = 16'h0000;
   logic [CHAN_W-1:0] chan = 2'h0;
   logic [NSEL_W-1:0] sel = 3'h0;
   logic mode = 1'b0;
   logic [ADDR_W-1:0] addr = 16'h0000;
   logic rd = 1'b0;
   logic word = 1'b0;
   logic done, rack, rhit, cint, fresh, lost, mode_q;
   logic [RES_W-1:0] rdata, mraw, rv, exp_w;
   logic [CHAN_W-1:0] mchan;
   int miscompares = 0;
   int cmp_count = 0;
   int n;
   // 50 MHz clock.
   always #10 clk = ~clk;
   sdr_mod_model u_sdr_mod_model(.clk_i(clk), .go_i(go), .raw_i(raw), .chan_i(chan),
      .done_o(done), .raw_o(mraw), .chan_o(mchan));
   sdr_result u_sdr_result(.SYS_CLK_I(clk), .RST_N_I(rst_n), .CONV_DONE_I(done),
      .CONV_RAW_I(mraw), .CONV_CHAN_I(mchan), .SAMPLE_SEL_I(sel), .INPUT_MODE_I(mode),
      .CPU_ADDR_I(addr), .CPU_RD_I(rd), .CPU_WORD_I(word), .CPU_RDATA_O(rdata),
      .CPU_RACK_O(rack), .CPU_RHIT_O(rhit), .CONV_INT_O(cint), .RESULT_FRESH_O(fresh),
      .RESULT_LOST_O(lost), .INPUT_MODE_O(mode_q));
   task automatic chk(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] want);
      cmp_count++;
      if (seen !== want) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   // One conversion; settings are held until the next one, as the control registers do.
   task automatic conv(input logic [RES_W-1:0] r, input logic [CHAN_W-1:0] c,
         input logic [NSEL_W-1:0] s, input logic m);
      @(posedge clk);
      go <= 1'b1;
      raw <= r;
      chan <= c;
      sel <= s;
      mode <= m;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      chk({15'h0, cint}, 16'h0001);
   endtask
   // One read, checked at the answer cycle.
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic w, input logic h,
         input logic [RES_W-1:0] want);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      word <= w;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({14'h0, rack, rhit}, {14'h0, 1'b1, h});
      chk(rdata, want);
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(ADDR_RES_LO, 1'b1, 1'b1, RES_RST);
      rd_chk(ADDR_RES_HI, 1'b0, 1'b1, 16'h0000);
      rd_chk(ADDR_STATUS, 1'b0, 1'b1, 16'h0000);
      // Every resolution code; channel and mode change along with it.
      for (int s = 0; s < 8; s++) begin
         n = (s == 0) ? 8 : s + 9;
         rv = 16'hA5C3 & (16'hFFFF >> (16 - n));
         exp_w = rv << (16 - n);
         conv(rv, 2'(s % 3), 3'(s), s[0]);
         chk({15'h0, fresh}, 16'h0001);
         rd_chk(ADDR_STATUS, 1'b0, 1'b1, {14'h0, chan});
         rd_chk(ADDR_RES_HI, 1'b0, 1'b1, {8'h00, exp_w[15:8]});
         rd_chk(ADDR_RES_LO, 1'b0, 1'b1, {8'h00, exp_w[7:0]});
         rd_chk(ADDR_RES_LO, 1'b1, 1'b1, exp_w);
         chk({15'h0, mode_q}, {15'h0, mode});
         chk({14'h0, fresh, lost}, 16'h0000);
      end
      rd_chk(ADDR_STATUS, 1'b1, 1'b0, 16'h0000);
      rd_chk(16'h1234, 1'b0, 1'b0, 16'h0000);
      // Two results without a read between them; the second replaces the first.
      conv(16'h00FF, 2'h2, 3'h0, 1'b1);
      conv(16'h0012, 2'h1, 3'h0, 1'b1);
      chk({15'h0, lost}, 16'h0001);
      rd_chk(ADDR_RES_LO, 1'b1, 1'b1, 16'h1200);
      // A second reset clears the contents again.
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(ADDR_RES_LO, 1'b1, 1'b1, RES_RST);
      rd_chk(ADDR_STATUS, 1'b0, 1'b1, 16'h0000);
      chk({14'h0, fresh, lost}, 16'h0000);
      tally_and_finish();
   end
   // Whole run takes a few microseconds; this limit only catches a hang.
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
endmodule // sdr_result_tb_top
bind sdr_result sdr_result_assertions u_sdr_result_assertions(.SYS_CLK_I(SYS_CLK_I),
   .RST_N_I(RST_N_I), .CONV_DONE_I(CONV_DONE_I), .CPU_ADDR_I(CPU_ADDR_I),
   .CPU_RD_I(CPU_RD_I), .CPU_WORD_I(CPU_WORD_I), .CPU_RDATA_O(CPU_RDATA_O),
   .CPU_RACK_O(CPU_RACK_O), .CPU_RHIT_O(CPU_RHIT_O), .CONV_INT_O(CONV_INT_O));
